//--- logic/bdsl_pkg.sv
/*
  Constants for the baud detect start and lower limit stage.
  Assumes 8-bit register port, one 250 MHz clock.
*/
package bdsl_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] BDSL_ADDR_START = 8'h10;
  localparam logic [7:0] BDSL_ADDR_LOWER = 8'h11;
  localparam logic [7:0] BDSL_ADDR_DIVCFG = 8'h04;
  localparam logic [7:0] BDSL_ADDR_DIVNOW = 8'h05;
  localparam logic [7:0] BDSL_RESET_VAL = 8'h00;
  localparam int BDSL_FIELD_W = 6;
  localparam logic [1:0] BDSL_RSV_READ = 2'h0;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam logic [5:0] BDSL_STEP_PERIODS_FAST = 6'h14;
  localparam logic [5:0] BDSL_STEP_PERIODS_SLOW = 6'h28;
  localparam int BDSL_CNT_W = 5;
  localparam logic [4:0] BDSL_CNT_TOP = 5'h1D;
  localparam logic [4:0] BDSL_CNT_WRAP = 5'h0A;
  localparam logic [4:0] BDSL_CNT_ZERO = 5'h00;
endpackage

//--- logic/bdsl_cnt_if.sv
/*
  Link between the top and one baud counter.
  Assumes both ends share the top clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface bdsl_cnt_if;
  logic tick;
  logic restart;
  logic [4:0] count;
  modport counter (input tick, input restart, output count);
  modport user (output tick, output restart, input count);
endinterface
`default_nettype wire

//--- logic/bdsl_baud_counter.sv
/*
  One like-transition baud counter, 0 up to 29 then wrap to 10.
  Assumes restart is a one-cycle pulse on clk; tick is a level enable, held high every clock at the fast rate.
*/
`timescale 1ns/100ps
`default_nettype none
module bdsl_baud_counter
  import bdsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  bdsl_cnt_if.counter cif
);
  logic [4:0] count_ff;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || cif.restart) begin
      count_ff <= BDSL_CNT_ZERO;
    end else if (cif.tick) begin
      if (count_ff == BDSL_CNT_TOP) begin
        count_ff <= BDSL_CNT_WRAP;
      end else begin
        count_ff <= count_ff + 5'h01;
      end
    end
  end
  assign cif.count = count_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_cnt_wrap: assert property (@(posedge clk) disable iff (rst)
    cif.tick && !cif.restart && count_ff == BDSL_CNT_TOP |=> count_ff == BDSL_CNT_WRAP)
    else $error("baud counter did not wrap to 10");
  a_cnt_restart: assert property (@(posedge clk) disable iff (rst)
    cif.restart |=> count_ff == BDSL_CNT_ZERO ##1 count_ff <= 5'h01)
    else $error("baud counter did not restart");
  a_cnt_hold: assert property (@(posedge clk) disable iff (rst)
    !cif.tick && !cif.restart |=> $stable(count_ff))
    else $error("baud counter moved without tick");
endmodule
`default_nettype wire

//--- logic/bdsl_top.sv
/*
  Baud detect start time and lower limit stage of a receive baud detector.
  Assumes rxd synchronous to clk and a plain one-cycle register port.
*/
`timescale 1ns/100ps
`default_nettype none
module bdsl_top
  import bdsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic clock_rate_select,
  input wire logic timer_restart,
  input wire logic rxd,
  output logic examining,
  output logic result_valid,
  output logic result_fail,
  output logic result_falling
);
  import bdsl_pkg::*;

  logic [5:0] start_ff;
  logic [5:0] lower_ff;
  logic [7:0] divcfg_ff;
  logic [7:0] timer_ff;
  logic [5:0] pre_ff;
  logic half_ff;
  logic rxd_ff;
  logic exam_ff;
  logic [1:0] armed_ff;
  logic [7:0] rdata_ff;
  logic res_valid_ff;
  logic res_fail_ff;
  logic res_falling_ff;
  logic step;
  logic baud_tick;
  logic [5:0] step_len;
  logic [1:0] edge_hit;
  logic [1:0] pair_fail;
  bdsl_cnt_if cnt_if[2] ();

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Upper bits of start and lower are dropped on write, so they read back as zero; divcfg keeps all 8 bits
  always_ff @(posedge clk) begin
    if (rst) begin
      start_ff <= BDSL_RESET_VAL[5:0];
      lower_ff <= BDSL_RESET_VAL[5:0];
      divcfg_ff <= BDSL_RESET_VAL;
    end else if (reg_wr) begin
      if (reg_addr == BDSL_ADDR_START) begin
        start_ff <= reg_wdata[BDSL_FIELD_W-1:0];
      end else if (reg_addr == BDSL_ADDR_LOWER) begin
        lower_ff <= reg_wdata[BDSL_FIELD_W-1:0];
      end else if (reg_addr == BDSL_ADDR_DIVCFG) begin
        divcfg_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= BDSL_RESET_VAL;
    end else if (reg_rd) begin
      if (reg_addr == BDSL_ADDR_START) begin
        rdata_ff <= {BDSL_RSV_READ, start_ff};
      end else if (reg_addr == BDSL_ADDR_LOWER) begin
        rdata_ff <= {BDSL_RSV_READ, lower_ff};
      end else if (reg_addr == BDSL_ADDR_DIVCFG) begin
        rdata_ff <= divcfg_ff;
      end else if (reg_addr == BDSL_ADDR_DIVNOW) begin
        rdata_ff <= timer_ff;
      end else begin
        rdata_ff <= BDSL_RESET_VAL;
      end
    end else begin
      rdata_ff <= BDSL_RESET_VAL;
    end
  end
  assign reg_rdata = rdata_ff;

  // ------------------------------------------------------------
  // Antenna diversity timer
  // ------------------------------------------------------------
  assign step_len = clock_rate_select ? BDSL_STEP_PERIODS_SLOW : BDSL_STEP_PERIODS_FAST;
  // Compare with >= so a rate change mid-step cannot overrun
  assign step = (pre_ff >= step_len - 6'h01);

  always_ff @(posedge clk) begin
    if (rst || timer_restart || step) begin
      pre_ff <= 6'h00;
    end else begin
      pre_ff <= pre_ff + 6'h01;
    end
  end

  // No diversity enable gates this: it always runs
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_ff <= BDSL_RESET_VAL;
    end else if (timer_restart) begin
      timer_ff <= divcfg_ff;
    end else if (step) begin
      if (timer_ff == 8'h00) begin
        timer_ff <= divcfg_ff;
      end else begin
        timer_ff <= timer_ff - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || timer_restart) begin
      exam_ff <= 1'b0;
    end else if (timer_ff == {2'h0, start_ff}) begin
      exam_ff <= 1'b1;
    end
  end
  assign examining = exam_ff;

  // ------------------------------------------------------------
  // Baud tick and edges
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      half_ff <= 1'b0;
      rxd_ff <= 1'b0;
    end else begin
      half_ff <= ~half_ff;
      rxd_ff <= rxd;
    end
  end
  assign baud_tick = !clock_rate_select || half_ff;
  assign edge_hit[0] = rxd && !rxd_ff;
  assign edge_hit[1] = !rxd && rxd_ff;

  // Index 0 rising, index 1 falling; one counter instance each
  for (genvar g = 0; g < 2; g++) begin : g_edge
    assign cnt_if[g].tick = baud_tick;
    assign cnt_if[g].restart = edge_hit[g] || timer_restart;
    assign pair_fail[g] = {1'b0, cnt_if[g].count} < lower_ff;
    bdsl_baud_counter u_cnt (
      .clk(clk),
      .rst(rst),
      .cif(cnt_if[g])
    );
    // First edge after start only opens a pair
    always_ff @(posedge clk) begin
      if (rst || timer_restart || !exam_ff) begin
        armed_ff[g] <= 1'b0;
      end else if (edge_hit[g]) begin
        armed_ff[g] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Pair result
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid_ff <= 1'b0;
      res_fail_ff <= 1'b0;
      res_falling_ff <= 1'b0;
    end else begin
      res_valid_ff <= 1'b0;
      if (exam_ff && edge_hit[0] && armed_ff[0]) begin
        res_valid_ff <= 1'b1;
        res_fail_ff <= pair_fail[0];
        res_falling_ff <= 1'b0;
      end else if (exam_ff && edge_hit[1] && armed_ff[1]) begin
        res_valid_ff <= 1'b1;
        res_fail_ff <= pair_fail[1];
        res_falling_ff <= 1'b1;
      end
    end
  end
  assign result_valid = res_valid_ff;
  assign result_fail = res_fail_ff;
  assign result_falling = res_falling_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_rsv_read_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == BDSL_ADDR_START |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  a_exam_start: assert property (@(posedge clk) disable iff (rst)
    $rose(exam_ff) |-> $past(timer_ff) == {2'h0, $past(start_ff)})
    else $error("examination began off the start time");
  a_timer_down: assert property (@(posedge clk) disable iff (rst)
    step && !timer_restart && timer_ff != 8'h00 |=> timer_ff == $past(timer_ff) - 8'h01)
    else $error("timer did not count down");
  a_step_spacing: assert property (@(posedge clk) disable iff (rst)
    step && !clock_rate_select |=> (!step) [*8])
    else $error("timer step too short");
  a_pair_fail: assert property (@(posedge clk) disable iff (rst)
    exam_ff && edge_hit[0] && armed_ff[0] && cnt_if[0].count < lower_ff[4:0]
    && lower_ff[5] == 1'b0 |=> result_valid && result_fail && !result_falling)
    else $error("short pair not failed");
  a_baud_half: assert property (@(posedge clk) disable iff (rst)
    clock_rate_select && baud_tick ##1 clock_rate_select |-> !baud_tick)
    else $error("slow baud tick too fast");
  a_timer_reload: assert property (@(posedge clk) disable iff (rst)
    step && !timer_restart && timer_ff == 8'h00 |=> timer_ff == $past(divcfg_ff))
    else $error("timer did not reload");
  a_timer_runs: assert property (@(posedge clk) disable iff (rst)
    step && !timer_restart && divcfg_ff != 8'h00 |=> timer_ff != $past(timer_ff))
    else $error("timer stalled");
endmodule
`default_nettype wire

//--- test/bdsl_radio_model.sv
/*
  Radio model: drives rxd with one rising and one falling pair.
  Assumes go is a one-cycle pulse and gap is 3 or more.
*/
`timescale 1ns/100ps
`default_nettype none
module bdsl_radio_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] gap,
  output logic rxd,
  output logic busy
);
  // ----
  // Pair generator
  // ----
  logic [7:0] cnt_ff;
  logic rxd_ff;
  logic busy_ff;
  assign rxd = rxd_ff;
  assign busy = busy_ff;
  // Rise, fall, rise at gap, fall at gap+1: both pairs span gap
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      rxd_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (go && !busy_ff) begin
      cnt_ff <= 8'h01;
      rxd_ff <= 1'b1;
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff + 8'h01;
      rxd_ff <= (cnt_ff == gap);
      busy_ff <= (cnt_ff != gap + 8'h01);
    end
  end
endmodule
`default_nettype wire

//--- test/bdsl_top_tb.sv
/*
  Self-checking bench for bdsl_top with a radio model on rxd.
  Assumes a 250 MHz clk and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module bdsl_top_tb;
  import bdsl_pkg::*;
  typedef struct packed {
    logic rate;
    logic [5:0] lo;
    logic [7:0] gap;
    logic fail;
  } bdsl_row_t;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic sel = 1'b0, rstrt = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, gap = 8'h05, rdata;
  logic rxd, busy, exam, rv, rf, rfall;
  logic [1:0] resq[$];
  int fails = 0, samples_checked = 0, cyc = 0, t0, k;
  // Gaps in clocks; 31 and 41 land on the wrapped counter values
  bdsl_row_t rows[8] = '{
    '{1'h0, 6'h05, 8'h05, 1'h1}, '{1'h0, 6'h04, 8'h05, 1'h0},
    '{1'h0, 6'h1D, 8'h1E, 1'h0}, '{1'h0, 6'h0B, 8'h1F, 1'h1},
    '{1'h0, 6'h14, 8'h29, 1'h0}, '{1'h0, 6'h15, 8'h29, 1'h1},
    '{1'h1, 6'h0C, 8'h14, 1'h1}, '{1'h1, 6'h08, 8'h14, 1'h0}};
  bdsl_top uut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .clock_rate_select(sel),
    .timer_restart(rstrt), .rxd(rxd), .examining(exam), .result_valid(rv),
    .result_fail(rf), .result_falling(rfall));
  bdsl_radio_model radio (.clk(clk), .rst(rst), .go(go), .gap(gap),
    .rxd(rxd), .busy(busy));
  // ----
  // Clock, monitor, watchdog
  // ----
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rv === 1'b1) resq.push_back({rfall, rf});
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    complete_run();
  end
  // ----
  // Tasks
  // ----
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask
  task complete_run;
    $display("Mismatches %0d, checks %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Reserved bits are masked off here, although they read back as zero
  task rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string s);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk((rdata & m) === e, s);
  endtask
  task pair(input logic [7:0] g);
    @(posedge clk);
    go <= 1'b1;
    gap <= g;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 300 && busy === 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task wait_to(input int n);
    while (cyc < n) @(posedge clk);
    #1;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(BDSL_ADDR_START, 8'h3F, BDSL_RESET_VAL, "start reset");
    rd_chk(BDSL_ADDR_LOWER, 8'h3F, BDSL_RESET_VAL, "lower reset");
    wr_reg(BDSL_ADDR_START, 8'h2A);
    rd_chk(BDSL_ADDR_START, 8'h3F, 8'h2A, "start readback");
    rd_chk(8'h30, 8'hFF, 8'h00, "unmapped read");
    wr_reg(BDSL_ADDR_START, 8'h00);
    foreach (rows[i]) begin
      sel <= rows[i].rate;
      wr_reg(BDSL_ADDR_LOWER, {2'h0, rows[i].lo});
      pair(rows[i].gap);
      chk(resq.size() > 1 && resq[$-1] === {1'b0, rows[i].fail}, "rise verdict");
      chk(resq.size() > 1 && resq[$] === {1'b1, rows[i].fail}, "fall verdict");
    end
    wr_reg(BDSL_ADDR_DIVCFG, 8'h03);
    wr_reg(BDSL_ADDR_START, 8'h01);
    for (int r = 0; r < 2; r++) begin
      sel <= r[0];
      k = 20 * (r + 1);
      @(posedge clk);
      rstrt <= 1'b1;
      t0 = cyc + 1;
      @(posedge clk);
      rstrt <= 1'b0;
      resq.delete();
      pair(8'h05);
      chk(resq.size() == 0, "result before start");
      wait_to(t0 + k + 5);
      rd_chk(BDSL_ADDR_DIVNOW, 8'hFF, 8'h02, "timer step");
      wait_to(t0 + 2 * k - 4);
      chk(exam === 1'b0, "examining early");
      wait_to(t0 + 2 * k + 6);
      chk(exam === 1'b1, "examining late");
    end
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(BDSL_ADDR_DIVCFG, 8'hFF, BDSL_RESET_VAL, "config after reset");
    complete_run();
  end
endmodule
`default_nettype wire
